// ===== logic/avs_actual_setpoint_select.sv
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module avs_actual_setpoint_select #(
  parameter int SAFETY_CYCLES = avs_pkg::SAFETY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] in1_code,
  input wire logic [11:0] in2_code,
  input wire logic [11:0] in3_code,
  input wire logic [11:0] in4_code,
  input wire logic setpoint_contact,
  output logic controller_on,
  output logic limiter_on,
  output logic safety_phase,
  output logic standby,
  output logic lockout,
  output logic [3:0] sensor_error,
  output logic [15:0] actual_value,
  output logic [15:0] active_setpoint,
  output logic [16:0] heat_demand,
  output logic [15:0] load_demand,
  output logic [1:0] load_stage
);
  typedef struct packed {
    logic [11:0] cfg;
    logic [15:0] temp_end;
    logic [15:0] press_end;
    logic [15:0] sp1;
    logic [15:0] sp2;
    logic [15:0] ext_min;
    logic [15:0] ext_max;
    logic [15:0] lim_val;
    logic [15:0] bus_sp;
    logic [15:0] bus_load;
    avs_pkg::avs_phase_t phase;
    logic [31:0] timer;
    logic [2:0] sync;
    logic contact;
    logic ack;
    logic [31:0] dat;
    logic [15:0] actual;
    logic [15:0] setpt;
    logic [16:0] demand;
    logic [15:0] load;
    logic [1:0] stage;
    logic ctrl_on;
    logic lim_on;
    logic [3:0] err;
  } avs_state_t;

  localparam logic [31:0] SAFE_LAST = 32'(SAFETY_CYCLES - 1);

  function automatic logic [31:0] avs_merge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : avs_merge

  function automatic logic [15:0] avs_min(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : avs_min

  function automatic logic [1:0] avs_stage(input logic [11:0] c);
    if (c >= avs_pkg::STAGE3_MIN) begin
      return 2'h3;
    end else if (c >= avs_pkg::STAGE2_MIN) begin
      return 2'h2;
    end else if (c >= avs_pkg::STAGE1_MIN) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : avs_stage

  avs_state_t st;
  avs_state_t nxt;

  // configuration decode
  logic [2:0] sel_code;
  logic rtd_hi;
  logic in2_press;
  logic [1:0] in2_type;
  logic in3_volt;
  logic [2:0] mode;
  logic multistage;
  assign sel_code = st.cfg[avs_pkg::CFG_SEL_LSB +: 3];
  assign rtd_hi = st.cfg[avs_pkg::CFG_RTD_HI];
  assign in2_press = st.cfg[avs_pkg::CFG_IN2_PRESS];
  assign in2_type = st.cfg[avs_pkg::CFG_IN2_TYPE_LSB +: 2];
  assign in3_volt = st.cfg[avs_pkg::CFG_IN3_VOLT];
  assign mode = st.cfg[avs_pkg::CFG_MODE_LSB +: 3];
  assign multistage = st.cfg[avs_pkg::CFG_MULTISTAGE];

  logic in1_used;
  logic in2_used;
  logic in4_used;
  logic lim_en;
  logic sp_mode;
  logic load_mode;
  logic in3_used;
  assign in1_used = (sel_code == avs_pkg::SEL_IN1) || (sel_code == avs_pkg::SEL_DUAL_PT) ||
                    (sel_code == avs_pkg::SEL_DUAL_NI);
  assign in4_used = (sel_code == avs_pkg::SEL_IN4_PT) || (sel_code == avs_pkg::SEL_IN4_NI) ||
                    (sel_code == avs_pkg::SEL_DUAL_PT) ||
                    (sel_code == avs_pkg::SEL_DUAL_NI);
  assign in2_used = (sel_code == avs_pkg::SEL_IN2_TEMP) ||
                    (sel_code == avs_pkg::SEL_IN2_PRESS);
  assign lim_en = in1_used || in4_used;
  assign sp_mode = (mode == avs_pkg::MODE_AN_SP);
  assign load_mode = (mode == avs_pkg::MODE_AN_LOAD) || (mode == avs_pkg::MODE_BUS_LOAD);
  assign in3_used = sp_mode || (mode == avs_pkg::MODE_AN_LOAD);

  logic [15:0] rtd_end;
  logic [15:0] in2_end;
  logic [15:0] range_end;
  logic [15:0] sp_cap;
  assign rtd_end = rtd_hi ? avs_pkg::RTD_END_HI : avs_pkg::RTD_END_LO;
  assign in2_end = in2_press ? st.press_end : st.temp_end;
  assign range_end = in2_used ? in2_end : rtd_end;
  assign sp_cap = lim_en ? avs_min(st.lim_val, range_end) : range_end;

  // measuring channels
  avs_chan_if ch1 ();
  avs_chan_if ch2 ();
  avs_chan_if ch3 ();
  avs_chan_if ch4 ();
  avs_chan_scale u_ch1 (.ch(ch1.conv));
  avs_chan_scale u_ch2 (.ch(ch2.conv));
  avs_chan_scale u_ch3 (.ch(ch3.conv));
  avs_chan_scale u_ch4 (.ch(ch4.conv));

  assign ch1.code = in1_code;
  assign ch1.zero = avs_pkg::RTD_ZERO;
  assign ch1.span = avs_pkg::RTD_SPAN;
  assign ch1.top = rtd_end;
  assign ch1.chk = 1'b1;
  assign ch4.code = in4_code;
  assign ch4.zero = avs_pkg::RTD_ZERO;
  assign ch4.span = avs_pkg::RTD_SPAN;
  assign ch4.top = rtd_end;
  assign ch4.chk = 1'b1;

  logic [11:0] in2_zero;
  assign in2_zero = (in2_type == avs_pkg::TYPE_0_10V) ? avs_pkg::CODE_DEAD_ZERO :
                    avs_pkg::CODE_LIVE_ZERO;
  assign ch2.code = in2_code;
  assign ch2.zero = in2_zero;
  assign ch2.span = avs_pkg::CODE_FULL - in2_zero;
  assign ch2.top = in2_end;
  assign ch2.chk = (in2_type != avs_pkg::TYPE_0_10V);

  // voltage on input 3 means 0-10 V only when it carries a setpoint
  logic [11:0] in3_zero;
  assign in3_zero = (in3_volt && sp_mode) ? avs_pkg::CODE_DEAD_ZERO :
                    avs_pkg::CODE_LIVE_ZERO;
  assign ch3.code = in3_code;
  assign ch3.zero = in3_zero;
  assign ch3.span = avs_pkg::CODE_FULL - in3_zero;
  assign ch3.top = sp_mode ? range_end : avs_pkg::LOAD_FULL;
  assign ch3.chk = in3_used && (in3_zero != avs_pkg::CODE_DEAD_ZERO);

  logic lim_fault;
  logic meas_fault;
  logic [3:0] err_now;
  assign lim_fault = (in1_used && ch1.fault) || (in4_used && ch4.fault);
  assign err_now = {in3_used && ch3.fault, in4_used && ch4.fault,
                    in2_used && ch2.fault, in1_used && ch1.fault};
  assign meas_fault = |err_now;

  logic [15:0] act_now;
  assign act_now = in1_used ? ch1.value :
                   in4_used ? ch4.value :
                   in2_used ? ch2.value : 16'h0000;

  // setpoint source
  logic [15:0] ext_sp;
  logic [15:0] sp_raw;
  logic [15:0] sp_now;
  assign ext_sp = (ch3.value < st.ext_min) ? st.ext_min :
                  (ch3.value > st.ext_max) ? st.ext_max : ch3.value;
  always_comb begin
    if (sp_mode) begin
      sp_raw = ext_sp;
    end else if (mode == avs_pkg::MODE_BUS_SP) begin
      sp_raw = st.bus_sp;
    end else begin
      sp_raw = st.contact ? st.sp2 : st.sp1;
    end
  end
  assign sp_now = avs_min(sp_raw, sp_cap);

  logic [15:0] load_now;
  assign load_now = (mode == avs_pkg::MODE_AN_LOAD) ? ch3.value :
                    (mode == avs_pkg::MODE_BUS_LOAD) ? st.bus_load : 16'h0000;

  logic ctrl_now;
  logic running;
  assign running = (st.phase == avs_pkg::PH_RUN);
  assign ctrl_now = running && !load_mode && !lim_fault &&
                    (sel_code != avs_pkg::SEL_NONE);

  // bus decode
  logic req;
  logic wr_en;
  logic [31:0] wr_word;
  logic [31:0] status;
  logic [31:0] rd_word;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && st.ack;

  always_comb begin
    status = 32'h0000_0000;
    status[avs_pkg::STS_ERR_LSB +: 4] = st.err;
    status[avs_pkg::STS_CTRL_ON] = st.ctrl_on;
    status[avs_pkg::STS_LIM_ON] = st.lim_on;
    status[avs_pkg::STS_LIM_EN] = lim_en;
    status[avs_pkg::STS_PHASE_LSB +: 2] = st.phase;
    status[avs_pkg::STS_STAGE_LSB +: 2] = st.stage;
    status[avs_pkg::STS_CONTACT] = st.contact;
  end

  always_comb begin
    if (wb_adr_i == avs_pkg::ADR_CFG) begin
      rd_word = {20'h00000, st.cfg};
    end else if (wb_adr_i == avs_pkg::ADR_RANGE) begin
      rd_word = {st.press_end, st.temp_end};
    end else if (wb_adr_i == avs_pkg::ADR_SETPT) begin
      rd_word = {st.sp2, st.sp1};
    end else if (wb_adr_i == avs_pkg::ADR_EXTSP) begin
      rd_word = {st.ext_max, st.ext_min};
    end else if (wb_adr_i == avs_pkg::ADR_LIMIT) begin
      rd_word = {16'h0000, st.lim_val};
    end else if (wb_adr_i == avs_pkg::ADR_BUS) begin
      rd_word = {st.bus_load, st.bus_sp};
    end else if (wb_adr_i == avs_pkg::ADR_STATUS) begin
      rd_word = status;
    end else if (wb_adr_i == avs_pkg::ADR_VALUE) begin
      rd_word = {st.setpt, st.actual};
    end else if (wb_adr_i == avs_pkg::ADR_DEMAND) begin
      rd_word = {st.load, 15'h0000, st.demand[16]};
      rd_word[15:0] = st.demand[15:0];
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  always_comb begin
    nxt = st;
    wr_word = 32'h0000_0000;
    // contact pin: three stages, change taken once the last two agree
    nxt.sync = {st.sync[1:0], setpoint_contact};
    if (st.sync[1] == st.sync[2]) begin
      nxt.contact = st.sync[2];
    end
    // single wait state: ack in the cycle after the request
    nxt.ack = req && !st.ack;
    if (req && !st.ack) begin
      nxt.dat = rd_word;
    end
    if (wr_en) begin
      if (wb_adr_i == avs_pkg::ADR_CFG) begin
        wr_word = avs_merge({20'h00000, st.cfg}, wb_dat_i, wb_sel_i);
        nxt.cfg = wr_word[11:0];
      end else if (wb_adr_i == avs_pkg::ADR_RANGE) begin
        wr_word = avs_merge({st.press_end, st.temp_end}, wb_dat_i, wb_sel_i);
        if (wr_word[15:0] <= avs_pkg::TEMP_END_MAX) begin
          nxt.temp_end = wr_word[15:0];
        end
        if (wr_word[31:16] <= avs_pkg::PRESS_END_MAX) begin
          nxt.press_end = wr_word[31:16];
        end
      end else if (wb_adr_i == avs_pkg::ADR_SETPT) begin
        wr_word = avs_merge({st.sp2, st.sp1}, wb_dat_i, wb_sel_i);
        // refused values leave the old setpoint in place
        if (wr_word[15:0] <= sp_cap) begin
          nxt.sp1 = wr_word[15:0];
        end
        if (wr_word[31:16] <= sp_cap) begin
          nxt.sp2 = wr_word[31:16];
        end
      end else if (wb_adr_i == avs_pkg::ADR_EXTSP) begin
        wr_word = avs_merge({st.ext_max, st.ext_min}, wb_dat_i, wb_sel_i);
        nxt.ext_min = wr_word[15:0];
        nxt.ext_max = wr_word[31:16];
      end else if (wb_adr_i == avs_pkg::ADR_LIMIT) begin
        wr_word = avs_merge({16'h0000, st.lim_val}, wb_dat_i, wb_sel_i);
        nxt.lim_val = wr_word[15:0];
      end else if (wb_adr_i == avs_pkg::ADR_BUS) begin
        wr_word = avs_merge({st.bus_load, st.bus_sp}, wb_dat_i, wb_sel_i);
        nxt.bus_sp = wr_word[15:0];
        nxt.bus_load = wr_word[31:16];
      end
    end
    // burner phase
    case (st.phase)
      avs_pkg::PH_RUN: begin
        if (meas_fault) begin
          nxt.phase = avs_pkg::PH_SAFETY;
          nxt.timer = 32'h0000_0000;
        end
      end
      avs_pkg::PH_SAFETY: begin
        if (!meas_fault) begin
          nxt.phase = avs_pkg::PH_STANDBY;
        end else if (st.timer == SAFE_LAST) begin
          nxt.phase = avs_pkg::PH_LOCKOUT;
        end else begin
          nxt.timer = st.timer + 32'h0000_0001;
        end
      end
      avs_pkg::PH_STANDBY: begin
        nxt.timer = 32'h0000_0000;
        nxt.phase = meas_fault ? avs_pkg::PH_SAFETY : avs_pkg::PH_RUN;
      end
      default: begin
        // lockout holds until software releases it
        if (wr_en && (wb_adr_i == avs_pkg::ADR_CTRL) && wb_sel_i[0] &&
            wb_dat_i[avs_pkg::CTRL_UNLOCK]) begin
          nxt.phase = avs_pkg::PH_STANDBY;
        end
      end
    endcase
    // registered outputs
    nxt.actual = act_now;
    nxt.setpt = sp_now;
    nxt.ctrl_on = ctrl_now;
    nxt.lim_on = lim_en && !lim_fault;
    nxt.err = err_now;
    nxt.demand = ctrl_now ? ({1'b0, sp_now} - {1'b0, act_now}) : 17'h00000;
    nxt.load = (running && load_mode) ? load_now : 16'h0000;
    nxt.stage = (running && multistage && (mode == avs_pkg::MODE_AN_LOAD)) ?
                avs_stage(in3_code) : 2'h0;
    if (sys_rst) begin
      nxt = '0;
      nxt.cfg = avs_pkg::CFG_RST;
      nxt.temp_end = avs_pkg::TEMP_END_MAX;
      nxt.press_end = avs_pkg::PRESS_END_MAX;
      nxt.ext_max = avs_pkg::TEMP_END_MAX;
      nxt.lim_val = avs_pkg::LIMIT_RST;
      nxt.phase = avs_pkg::PH_STANDBY;
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= nxt;
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign controller_on = st.ctrl_on;
  assign limiter_on = st.lim_on;
  assign safety_phase = (st.phase == avs_pkg::PH_SAFETY);
  assign standby = (st.phase == avs_pkg::PH_STANDBY);
  assign lockout = (st.phase == avs_pkg::PH_LOCKOUT);
  assign sensor_error = st.err;
  assign actual_value = st.actual;
  assign active_setpoint = st.setpt;
  assign heat_demand = st.demand;
  assign load_demand = st.load;
  assign load_stage = st.stage;
endmodule : avs_actual_setpoint_select

// ===== logic/avs_pkg.sv
package avs_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_RANGE = 8'h04;
  localparam logic [7:0] ADR_SETPT = 8'h08;
  localparam logic [7:0] ADR_EXTSP = 8'h0c;
  localparam logic [7:0] ADR_LIMIT = 8'h10;
  localparam logic [7:0] ADR_BUS = 8'h14;
  localparam logic [7:0] ADR_CTRL = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1c;
  localparam logic [7:0] ADR_VALUE = 8'h20;
  localparam logic [7:0] ADR_DEMAND = 8'h24;
  // configuration fields
  localparam int CFG_W = 12;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_RTD_HI = 3;
  localparam int CFG_IN2_PRESS = 4;
  localparam int CFG_IN2_TYPE_LSB = 5;
  localparam int CFG_IN3_VOLT = 7;
  localparam int CFG_MODE_LSB = 8;
  localparam int CFG_MULTISTAGE = 11;
  localparam logic [11:0] CFG_RST = 12'h000;
  localparam int CTRL_UNLOCK = 0;
  // status fields
  localparam int STS_ERR_LSB = 0;
  localparam int STS_CTRL_ON = 4;
  localparam int STS_LIM_ON = 5;
  localparam int STS_LIM_EN = 6;
  localparam int STS_PHASE_LSB = 7;
  localparam int STS_STAGE_LSB = 9;
  localparam int STS_CONTACT = 11;
  // sensor selection codes
  localparam logic [2:0] SEL_IN1 = 3'h0;
  localparam logic [2:0] SEL_IN4_PT = 3'h1;
  localparam logic [2:0] SEL_IN4_NI = 3'h2;
  localparam logic [2:0] SEL_IN2_TEMP = 3'h3;
  localparam logic [2:0] SEL_IN2_PRESS = 3'h4;
  localparam logic [2:0] SEL_DUAL_PT = 3'h5;
  localparam logic [2:0] SEL_DUAL_NI = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // load control modes
  localparam logic [2:0] MODE_INT = 3'h0;
  localparam logic [2:0] MODE_AN_SP = 3'h1;
  localparam logic [2:0] MODE_AN_LOAD = 3'h2;
  localparam logic [2:0] MODE_BUS_SP = 3'h3;
  localparam logic [2:0] MODE_BUS_LOAD = 3'h4;
  // input 2 signal types
  localparam logic [1:0] TYPE_0_10V = 2'h0;
  localparam logic [1:0] TYPE_2_10V = 2'h1;
  localparam logic [1:0] TYPE_4_20MA = 2'h2;
  // converter codes: full scale 12'hfff is 10 V or 20 mA
  localparam logic [11:0] CODE_DEAD_ZERO = 12'h000;
  localparam logic [11:0] CODE_LIVE_ZERO = 12'h333;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  localparam logic [11:0] RTD_ZERO = 12'h19a;
  localparam logic [11:0] RTD_SPAN = 12'hccc;
  localparam logic [11:0] CODE_MARGIN = 12'h148;
  localparam logic [11:0] STAGE1_MIN = 12'h200;
  localparam logic [11:0] STAGE2_MIN = 12'h600;
  localparam logic [11:0] STAGE3_MIN = 12'ha00;
  // ranges: temperature in 0.1 degC, pressure in 0.01 bar, load in 0.1 %
  localparam logic [15:0] RTD_END_LO = 16'h05dc;
  localparam logic [15:0] RTD_END_HI = 16'h0fa0;
  localparam logic [15:0] TEMP_END_MAX = 16'h4e20;
  localparam logic [15:0] PRESS_END_MAX = 16'h2710;
  localparam logic [15:0] LOAD_FULL = 16'h03e8;
  localparam logic [15:0] LIMIT_RST = 16'h0fa0;
  // safety phase length
  localparam int CLK_MHZ = 100;
  localparam int SAFETY_MS = 10;
  localparam int SAFETY_CYCLES = SAFETY_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {PH_RUN, PH_SAFETY, PH_STANDBY, PH_LOCKOUT} avs_phase_t;
endpackage : avs_pkg

// ===== logic/avs_chan_if.sv
`timescale 1ns/1ps
interface avs_chan_if;
  logic [11:0] code;
  logic [11:0] zero;
  logic [11:0] span;
  logic [15:0] top;
  logic chk;
  logic [15:0] value;
  logic fault;
  modport conv (input code, input zero, input span, input top, input chk,
                output value, output fault);
  modport user (output code, output zero, output span, output top, output chk,
                input value, input fault);
endinterface : avs_chan_if

// ===== logic/avs_chan_scale.sv
`timescale 1ns/1ps
module avs_chan_scale (
  avs_chan_if.conv ch
);
  logic [13:0] lo_lim;
  logic [13:0] hi_lim;
  logic [13:0] top_code;
  logic [11:0] off;
  logic [27:0] prod;

  assign top_code = {2'h0, ch.zero} + {2'h0, ch.span};
  assign lo_lim = {2'h0, ch.code} + {2'h0, avs_pkg::CODE_MARGIN};
  assign hi_lim = top_code + {2'h0, avs_pkg::CODE_MARGIN};
  assign off = ch.code - ch.zero;
  assign prod = off * ch.top;

  always_comb begin
    if (ch.code <= ch.zero) begin
      ch.value = 16'h0000;
    end else if ({2'h0, ch.code} >= top_code) begin
      ch.value = ch.top;
    end else begin
      ch.value = 16'(prod / {16'h0000, ch.span});
    end
  end

  // a dead-zero signal cannot tell a broken line from zero
  assign ch.fault = ch.chk && ((lo_lim < {2'h0, ch.zero}) ||
                    ({2'h0, ch.code} > hi_lim));
endmodule : avs_chan_scale

// ===== bench/avs_monitor.sv
`timescale 1ns/1ps
module avs_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic controller_on,
  input wire logic limiter_on,
  input wire logic safety_phase,
  input wire logic standby,
  input wire logic lockout,
  input wire logic [3:0] sensor_error,
  input wire logic [16:0] heat_demand,
  input wire logic [15:0] load_demand
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack stretched");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_phase_one; $onehot0({safety_phase, standby, lockout}); endproperty
  a_phase_one: assert property (p_phase_one) else $error("phases overlap");
  property p_clear; safety_phase && sensor_error == 4'h0 |-> ##[0:2] standby; endproperty
  a_clear: assert property (p_clear) else $error("no standby after clear");
  property p_lock_src; $rose(lockout) |-> $past(safety_phase); endproperty
  a_lock_src: assert property (p_lock_src) else $error("lockout not from safety");
  // only a bus write may end lockout
  property p_lock_hold; lockout && !wb_cyc_i && !$past(wb_cyc_i) |=> lockout; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left");
  property p_lock_off; lockout |-> !controller_on && heat_demand == 17'h0; endproperty
  a_lock_off: assert property (p_lock_off) else $error("burner on in lockout");
  property p_lim_fault; sensor_error[2] |-> ##[0:1] (!controller_on && !limiter_on); endproperty
  a_lim_fault: assert property (p_lim_fault) else $error("on with limiter fault");
  property p_load_max; load_demand <= avs_pkg::LOAD_FULL; endproperty
  a_load_max: assert property (p_load_max) else $error("load above full");
  property p_load_gate; controller_on |-> load_demand == 16'h0; endproperty
  a_load_gate: assert property (p_load_gate) else $error("load with controller");
  c_lockout: cover property ($rose(lockout));
  c_standby: cover property ($rose(standby));
  c_full: cover property (load_demand == avs_pkg::LOAD_FULL);
endmodule : avs_monitor

bind avs_actual_setpoint_select avs_monitor i_avs_monitor (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .controller_on(controller_on), .limiter_on(limiter_on), .safety_phase(safety_phase),
  .standby(standby), .lockout(lockout), .sensor_error(sensor_error),
  .heat_demand(heat_demand), .load_demand(load_demand));

// ===== bench/avs_sensor_model.sv
`timescale 1ns/1ps
// converters resample every clock, so a new level shows one edge later
module avs_sensor_model (
  input wire logic ref_clk,
  input wire logic [47:0] lvl,
  input wire logic cls,
  output logic [11:0] in1_code,
  output logic [11:0] in2_code,
  output logic [11:0] in3_code,
  output logic [11:0] in4_code,
  output logic setpoint_contact
);
  always_ff @(posedge ref_clk) begin
    {in1_code, in2_code, in3_code, in4_code} <= lvl;
    setpoint_contact <= cls;
  end
endmodule : avs_sensor_model

// ===== bench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module testbench;
  logic ref_clk, sys_rst, cyc, we_r, cls, ack, ct;
  logic [7:0] adr;
  logic [31:0] dat, dat_o;
  logic [11:0] c1, c2, c3, c4, i1, i2, i3, i4;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [15:0] sp;
  logic [15:0] av, asp, ld;
  logic [16:0] hd;
  logic [3:0] se;
  logic [1:0] ls;
  logic con, lon, sfp, sby, lko;
  int errors, cmp_count;
  avs_sensor_model i_avs_sensor_model (.ref_clk(ref_clk), .lvl({c1, c2, c3, c4}), .cls(cls),
    .in1_code(i1), .in2_code(i2), .in3_code(i3), .in4_code(i4), .setpoint_contact(ct));
  avs_actual_setpoint_select #(.SAFETY_CYCLES(16)) i_avs_actual_setpoint_select (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we_r),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .in1_code(i1), .in2_code(i2), .in3_code(i3), .in4_code(i4), .setpoint_contact(ct),
    .controller_on(con), .limiter_on(lon), .safety_phase(sfp), .standby(sby), .lockout(lko),
    .sensor_error(se), .actual_value(av), .active_setpoint(asp), .heat_demand(hd),
    .load_demand(ld), .load_stage(ls));
  // mask zero means write; otherwise read and note the masked expectation
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    repeat (3) @(posedge ref_clk);
    cyc <= 1'h1;
    we_r <= (m == 32'h0);
    adr <= a;
    dat <= d;
    if (m != 32'h0) q.push_back({m, d & m});
    do @(posedge ref_clk); while (!ack);
    cyc <= 1'h0;
  endtask : wb
  always @(posedge ref_clk) begin
    if (ack && cyc && !we_r) begin
      e = q.pop_front();
      `CHK(dat_o & e[63:32], e[31:0])
      // output pins must agree with the register view of the same access
      if (adr == 8'h20) `CHK({asp, av} & e[63:32], e[31:0])
      if (adr == 8'h24) `CHK({ld, hd[15:0]} & e[63:32], e[31:0])
      // demand stays within 15 bits of magnitude, so its sign copies bit 15
      if (adr == 8'h24 && e[47]) `CHK(hd[16], e[15])
      if (adr == 8'h1c) begin
        `CHK(se & e[35:32], e[3:0])
        `CHK({lon, con} & e[37:36], e[5:4])
        `CHK({lko | sby, lko | sfp} & e[40:39], e[8:7])
        `CHK(ls & e[42:41], e[10:9])
      end
    end
  end
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #60000;
    errors++;
    finish_test();
  end
  initial begin
    {sys_rst, cyc, we_r, cls, adr, dat} = {4'h8, 40'h0};
    {c1, c2, c3, c4} = {12'h800, 12'h333, 12'h333, 12'h800};
    sp = 16'($urandom(70025));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'h0;
    wb(8'h04, 32'h2710_4e20, '1);
    wb(8'h10, 32'h0fa0, 32'hffff);
    wb(8'h28, '1, 32'h0);
    wb(8'h28, 32'h0, '1);
    for (int s = 0; s < 8; s++) begin
      wb(8'h00, 32'(s), 32'h0);
      wb(8'h1c, 32'(s inside {0, 1, 2, 5, 6}) << 6, 32'h40);
    end
    wb(8'h00, 32'h8, 32'h0);
    wb(8'h20, 32'h07d0, 32'hffff);
    repeat (4) begin
      sp = 16'($urandom % (avs_pkg::LIMIT_RST + 16'h1));
      wb(8'h08, {16'h0, sp}, 32'h0);
      wb(8'h08, {16'h0, sp}, 32'hffff);
    end
    wb(8'h00, 32'h0, 32'h0);
    wb(8'h20, 32'h02ee, 32'hffff);
    wb(8'h08, 32'h00c8_05dd, 32'h0);
    wb(8'h08, {16'h00c8, sp}, '1);
    wb(8'h08, 32'h00c8_0064, 32'h0);
    wb(8'h10, 32'h0096, 32'h0);
    wb(8'h08, 32'h0097_0064, 32'h0);
    wb(8'h08, 32'h00c8_0064, '1);
    wb(8'h10, 32'h0fa0, 32'h0);
    wb(8'h20, 32'h0064_02ee, '1);
    wb(8'h24, 32'h0000_fd76, 32'hffff);
    cls <= 1'h1;
    // contact crosses the model and three sync stages before it counts
    repeat (4) @(posedge ref_clk);
    wb(8'h20, 32'h00c8_02ee, '1);
    cls <= 1'h0;
    wb(8'h00, 32'h43, 32'h0);
    wb(8'h20, 32'h0, 32'hffff);
    c2 <= 12'hfff;
    wb(8'h20, 32'h4e20, 32'hffff);
    c2 <= 12'h000;
    wb(8'h1c, 32'h082, 32'h18f);
    repeat (20) @(posedge ref_clk);
    c2 <= 12'h333;
    wb(8'h1c, 32'h180, 32'h18f);
    wb(8'h18, 32'h1, 32'h0);
    wb(8'h1c, 32'h0, 32'h18f);
    c2 <= 12'h000;
    repeat (3) @(posedge ref_clk);
    c2 <= 12'h333;
    wb(8'h1c, 32'h0, 32'h18f);
    wb(8'h00, 32'h3, 32'h0);
    c2 <= 12'h000;
    wb(8'h1c, 32'h0, 32'h18f);
    c2 <= 12'hfff;
    wb(8'h00, 32'h34, 32'h0);
    wb(8'h20, 32'h2710, 32'hffff);
    wb(8'h04, 32'h2711_4e21, 32'h0);
    wb(8'h04, 32'h2710_4e20, '1);
    wb(8'h0c, 32'h03e8_0064, 32'h0);
    c3 <= 12'h000;
    wb(8'h00, 32'h180, 32'h0);
    wb(8'h20, 32'h0064_0000, 32'hffff_0000);
    c3 <= 12'hfff;
    wb(8'h20, 32'h03e8_0000, 32'hffff_0000);
    c3 <= 12'h333;
    wb(8'h00, 32'h280, 32'h0);
    wb(8'h24, 32'h0, '1);
    wb(8'h1c, 32'h60, 32'h70);
    c3 <= 12'hfff;
    wb(8'h24, 32'h03e8_0000, '1);
    c3 <= 12'h000;
    wb(8'h1c, 32'h8, 32'h8);
    c3 <= 12'h333;
    wb(8'h00, 32'ha80, 32'h0);
    for (int k = 1; k < 4; k++) begin
      c3 <= 12'(k * 1024);
      wb(8'h1c, 32'(k) << 9, 32'h600);
    end
    wb(8'h14, 32'h01f4_012c, 32'h0);
    wb(8'h00, 32'h300, 32'h0);
    wb(8'h20, 32'h012c_0000, 32'hffff_0000);
    wb(8'h00, 32'h400, 32'h0);
    wb(8'h24, 32'h01f4_0000, 32'hffff_0000);
    wb(8'h00, 32'h5, 32'h0);
    c4 <= 12'h000;
    wb(8'h1c, 32'h4, 32'h34);
    repeat (3) @(posedge ref_clk);
    finish_test();
  end
endmodule : testbench
